// ### pkg/txc_pkg.sv
// Package with register map, field positions and carrier types of the transmit post-filter chain.
package txc_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int SAMP_W = 16;
    localparam int OUT_W = 18;
    localparam int ACC_W = 48;
    localparam int CIC_ORDER = 5;
    localparam int RAMP_DEPTH = 64;
    localparam int RAMP_W = 14;
    localparam int RAMP_IDX_W = 6;
    localparam int REST_W = 5;
    localparam int SHIFT_W = 6;
    localparam int SCALE_W = 14;

    localparam logic [ADDR_W-1:0] OFS_CIC_SHIFT = 9'h006;
    localparam logic [ADDR_W-1:0] OFS_RESAMPLING_SECOND_ORDER_STAGE_DECIM = 9'h007;
    localparam logic [ADDR_W-1:0] OFS_RESAMPLING_SECOND_ORDER_STAGE_INTERP = 9'h008;
    localparam logic [ADDR_W-1:0] OFS_FIFTH_ORDER_INTERPOLATOR_INTERP = 9'h009;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 9'h00D;
    localparam logic [ADDR_W-1:0] OFS_FINE_SCALE = 9'h00E;
    localparam logic [ADDR_W-1:0] OFS_EQ_COEF_ONE = 9'h010;
    localparam logic [ADDR_W-1:0] OFS_EQ_COEF_TWO = 9'h011;
    localparam logic [ADDR_W-1:0] OFS_RAMP_LEN0 = 9'h017;
    localparam logic [ADDR_W-1:0] OFS_RAMP_LEN1 = 9'h018;
    localparam logic [ADDR_W-1:0] OFS_RAMP_REST = 9'h019;
    localparam logic [ADDR_W-1:0] OFS_RAMP_STATUS = 9'h01E;
    localparam logic [ADDR_W-1:0] OFS_RAMP_RAM_LO = 9'h040;
    localparam logic [ADDR_W-1:0] OFS_RAMP_RAM_HI = 9'h07F;

    localparam int CTRL_RAMP_EN = 0;
    localparam int CTRL_RAMP_INTERP = 1;
    localparam int CTRL_EQ_EN = 5;
    localparam int CTRL_STD_SEL = 6;
    localparam int CTRL_W = 7;

    localparam int COEF_FRAC = 14;
    localparam int SCALE_FRAC = 14;
    localparam int RAMP_FRAC = 14;
    localparam logic [RAMP_W:0] RAMP_UNITY = 15'h4000;
    localparam logic [SHIFT_W-1:0] SHIFT_MIN = 6'h04;
    localparam logic [SHIFT_W-1:0] SHIFT_MAX = 6'h20;

    localparam logic [SHIFT_W-1:0] RST_CIC_SHIFT = 6'h04;
    localparam logic [SCALE_W-1:0] RST_FINE_SCALE = 14'h3FFF;
    localparam logic [DATA_W-1:0] RST_ZERO = 16'h0000;

    typedef struct packed {
        logic valid;
        logic marker;
        logic [1:0][SAMP_W-1:0] d;
    } txc_samp_type;

    typedef enum logic [1:0] {
        RAMP_IDLE,
        RAMP_UP,
        RAMP_HOLD,
        RAMP_DOWN
    } txc_ramp_state_type;
endpackage : txc_pkg

// ### logic/txc_chain.sv
// Transmit post-filter chain: phase equalizer, fine scaler, power ramp and fifth-order CIC.
`timescale 1ns/1ns
`default_nettype none
module txc_chain (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Samples from the coefficient filter.
    input wire logic in_valid,
    input wire logic in_marker,
    input wire logic [15:0] in_i,
    input wire logic [15:0] in_q,
    // Microprocessor port.
    input wire logic [txc_pkg::ADDR_W-1:0] up_addr,
    input wire logic up_wr,
    input wire logic up_rd,
    input wire logic [txc_pkg::DATA_W-1:0] up_wdata,
    output logic [txc_pkg::DATA_W-1:0] up_rdata,
    // Samples and resampling stage settings toward the resampler and tuner.
    output logic out_valid,
    output logic [txc_pkg::OUT_W-1:0] out_i,
    output logic [txc_pkg::OUT_W-1:0] out_q,
    output logic [11:0] resampling_second_order_stage_interp_m1,
    output logic [8:0] resampling_second_order_stage_decim_m1
);
    logic [txc_pkg::SHIFT_W-1:0] cic_shift_value, next_cic_shift_value;
    logic [7:0] fifth_order_interpolator_interp_factor, next_fifth_order_interpolator_interp_factor;
    logic [txc_pkg::CTRL_W-1:0] ctrl, next_ctrl;
    logic [txc_pkg::SCALE_W-1:0] fine_scale, next_fine_scale;
    logic [15:0] equalizer_coef_one, next_equalizer_coef_one;
    logic [15:0] equalizer_coef_two, next_equalizer_coef_two;
    logic [txc_pkg::RAMP_IDX_W-1:0] ramp_len0, next_ramp_len0, ramp_len1, next_ramp_len1;
    logic [txc_pkg::REST_W-1:0] ramp_rest, next_ramp_rest;
    logic [11:0] next_resampling_second_order_stage_interp_m1;
    logic [8:0] next_resampling_second_order_stage_decim_m1;
    logic [txc_pkg::DATA_W-1:0] next_up_rdata;
    logic [txc_pkg::RAMP_W-1:0] ramp_ram [txc_pkg::RAMP_DEPTH];
    logic ram_hit;

    txc_pkg::txc_samp_type s1, next_s1, s2, next_s2, s3, next_s3;
    txc_pkg::txc_ramp_state_type ramp_state, next_ramp_state;
    logic [txc_pkg::RAMP_IDX_W-1:0] ramp_idx, next_ramp_idx, ramp_top;
    logic ramp_sub, next_ramp_sub;
    logic [txc_pkg::REST_W-1:0] hold_cnt, next_hold_cnt;
    logic [txc_pkg::RAMP_W:0] gain;
    logic [7:0] cic_left, next_cic_left;
    logic cic_run;
    logic [txc_pkg::SHIFT_W-1:0] shift_eff;
    logic [1:0][txc_pkg::OUT_W-1:0] cic_out;
    logic [1:0][txc_pkg::SAMP_W-1:0] eq_y, sc_y, rp_y;

    function automatic logic [15:0] sat16(input logic signed [txc_pkg::ACC_W-1:0] v);
        if (v > 48'sh0000_0000_7FFF) begin
            sat16 = 16'h7FFF;
        end else if (v < -48'sh0000_0000_8000) begin
            sat16 = 16'h8000;
        end else begin
            sat16 = v[15:0];
        end
    endfunction : sat16

    // Microprocessor register writes and read answers.
    assign ram_hit = (up_addr >= txc_pkg::OFS_RAMP_RAM_LO) && (up_addr <= txc_pkg::OFS_RAMP_RAM_HI);
    always_comb begin
        next_cic_shift_value = cic_shift_value;
        next_fifth_order_interpolator_interp_factor = fifth_order_interpolator_interp_factor;
        next_ctrl = ctrl;
        next_fine_scale = fine_scale;
        next_equalizer_coef_one = equalizer_coef_one;
        next_equalizer_coef_two = equalizer_coef_two;
        next_ramp_len0 = ramp_len0;
        next_ramp_len1 = ramp_len1;
        next_ramp_rest = ramp_rest;
        next_resampling_second_order_stage_interp_m1 = resampling_second_order_stage_interp_m1;
        next_resampling_second_order_stage_decim_m1 = resampling_second_order_stage_decim_m1;
        next_up_rdata = up_rdata;
        if (up_wr) begin
            if (up_addr == txc_pkg::OFS_CIC_SHIFT) begin
                next_cic_shift_value = up_wdata[txc_pkg::SHIFT_W-1:0];
            end else if (up_addr == txc_pkg::OFS_RESAMPLING_SECOND_ORDER_STAGE_DECIM) begin
                next_resampling_second_order_stage_decim_m1 = up_wdata[8:0];
            end else if (up_addr == txc_pkg::OFS_RESAMPLING_SECOND_ORDER_STAGE_INTERP) begin
                next_resampling_second_order_stage_interp_m1 = up_wdata[11:0];
            end else if (up_addr == txc_pkg::OFS_FIFTH_ORDER_INTERPOLATOR_INTERP) begin
                next_fifth_order_interpolator_interp_factor = up_wdata[7:0];
            end else if (up_addr == txc_pkg::OFS_CTRL) begin
                next_ctrl = up_wdata[txc_pkg::CTRL_W-1:0];
            end else if (up_addr == txc_pkg::OFS_FINE_SCALE) begin
                next_fine_scale = up_wdata[txc_pkg::SCALE_W-1:0];
            end else if (up_addr == txc_pkg::OFS_EQ_COEF_ONE) begin
                next_equalizer_coef_one = up_wdata;
            end else if (up_addr == txc_pkg::OFS_EQ_COEF_TWO) begin
                next_equalizer_coef_two = up_wdata;
            end else if (up_addr == txc_pkg::OFS_RAMP_LEN0) begin
                next_ramp_len0 = up_wdata[txc_pkg::RAMP_IDX_W-1:0];
            end else if (up_addr == txc_pkg::OFS_RAMP_LEN1) begin
                next_ramp_len1 = up_wdata[txc_pkg::RAMP_IDX_W-1:0];
            end else if (up_addr == txc_pkg::OFS_RAMP_REST) begin
                next_ramp_rest = up_wdata[txc_pkg::REST_W-1:0];
            end
        end
        if (up_rd) begin
            if (up_addr == txc_pkg::OFS_CIC_SHIFT) begin
                next_up_rdata = 16'(cic_shift_value);
            end else if (up_addr == txc_pkg::OFS_RESAMPLING_SECOND_ORDER_STAGE_DECIM) begin
                next_up_rdata = 16'(resampling_second_order_stage_decim_m1);
            end else if (up_addr == txc_pkg::OFS_RESAMPLING_SECOND_ORDER_STAGE_INTERP) begin
                next_up_rdata = 16'(resampling_second_order_stage_interp_m1);
            end else if (up_addr == txc_pkg::OFS_FIFTH_ORDER_INTERPOLATOR_INTERP) begin
                next_up_rdata = 16'(fifth_order_interpolator_interp_factor);
            end else if (up_addr == txc_pkg::OFS_CTRL) begin
                next_up_rdata = 16'(ctrl);
            end else if (up_addr == txc_pkg::OFS_FINE_SCALE) begin
                next_up_rdata = 16'(fine_scale);
            end else if (up_addr == txc_pkg::OFS_EQ_COEF_ONE) begin
                next_up_rdata = equalizer_coef_one;
            end else if (up_addr == txc_pkg::OFS_EQ_COEF_TWO) begin
                next_up_rdata = equalizer_coef_two;
            end else if (up_addr == txc_pkg::OFS_RAMP_LEN0) begin
                next_up_rdata = 16'(ramp_len0);
            end else if (up_addr == txc_pkg::OFS_RAMP_LEN1) begin
                next_up_rdata = 16'(ramp_len1);
            end else if (up_addr == txc_pkg::OFS_RAMP_REST) begin
                next_up_rdata = 16'(ramp_rest);
            end else if (up_addr == txc_pkg::OFS_RAMP_STATUS) begin
                next_up_rdata = {6'h00, 2'(ramp_state), 2'h0, ramp_idx};
            end else if (ram_hit) begin
                next_up_rdata = 16'(ramp_ram[up_addr[txc_pkg::RAMP_IDX_W-1:0]]);
            end else begin
                next_up_rdata = txc_pkg::RST_ZERO;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cic_shift_value <= txc_pkg::RST_CIC_SHIFT;
            fifth_order_interpolator_interp_factor <= '0;
            ctrl <= '0;
            fine_scale <= txc_pkg::RST_FINE_SCALE;
            equalizer_coef_one <= txc_pkg::RST_ZERO;
            equalizer_coef_two <= txc_pkg::RST_ZERO;
            ramp_len0 <= '0;
            ramp_len1 <= '0;
            ramp_rest <= '0;
            resampling_second_order_stage_interp_m1 <= '0;
            resampling_second_order_stage_decim_m1 <= '0;
            up_rdata <= txc_pkg::RST_ZERO;
        end else begin
            cic_shift_value <= next_cic_shift_value;
            fifth_order_interpolator_interp_factor <= next_fifth_order_interpolator_interp_factor;
            ctrl <= next_ctrl;
            fine_scale <= next_fine_scale;
            equalizer_coef_one <= next_equalizer_coef_one;
            equalizer_coef_two <= next_equalizer_coef_two;
            ramp_len0 <= next_ramp_len0;
            ramp_len1 <= next_ramp_len1;
            ramp_rest <= next_ramp_rest;
            resampling_second_order_stage_interp_m1 <= next_resampling_second_order_stage_interp_m1;
            resampling_second_order_stage_decim_m1 <= next_resampling_second_order_stage_decim_m1;
            up_rdata <= next_up_rdata;
        end
    end

    // The ramp memory holds no reset value; software loads it before use.
    always_ff @(posedge clk_sys) begin
        if (up_wr && ram_hit) begin
            ramp_ram[up_addr[txc_pkg::RAMP_IDX_W-1:0]] <= up_wdata[txc_pkg::RAMP_W-1:0];
        end
    end

    // Ramp sequencer advances once per sample leaving the fine scaler.
    assign ramp_top = ctrl[txc_pkg::CTRL_STD_SEL] ? ramp_len1 : ramp_len0;
    always_comb begin
        next_ramp_state = ramp_state;
        next_ramp_idx = ramp_idx;
        next_ramp_sub = ramp_sub;
        next_hold_cnt = hold_cnt;
        gain = '0;
        case (ramp_state)
            txc_pkg::RAMP_UP: begin
                gain = {1'b0, ramp_ram[ramp_idx]};
                if (ramp_sub && ramp_idx != ramp_top) begin
                    gain = (15'(ramp_ram[ramp_idx]) + 15'(ramp_ram[ramp_idx + 6'h01])) >> 1;
                end
            end
            txc_pkg::RAMP_HOLD: begin
                gain = {1'b0, ramp_ram[ramp_top]};
            end
            txc_pkg::RAMP_DOWN: begin
                gain = {1'b0, ramp_ram[ramp_idx]};
                if (ramp_sub && ramp_idx != '0) begin
                    gain = (15'(ramp_ram[ramp_idx]) + 15'(ramp_ram[ramp_idx - 6'h01])) >> 1;
                end
            end
            default: begin
                gain = '0;
            end
        endcase
        if (!ctrl[txc_pkg::CTRL_RAMP_EN]) begin
            gain = txc_pkg::RAMP_UNITY;
            next_ramp_state = txc_pkg::RAMP_IDLE;
        end else if (s2.valid) begin
            case (ramp_state)
                txc_pkg::RAMP_IDLE: begin
                    if (s2.marker) begin
                        next_ramp_state = txc_pkg::RAMP_UP;
                        next_ramp_idx = '0;
                        next_ramp_sub = 1'b0;
                    end
                end
                txc_pkg::RAMP_UP: begin
                    if (ctrl[txc_pkg::CTRL_RAMP_INTERP] && !ramp_sub) begin
                        next_ramp_sub = 1'b1;
                    end else begin
                        next_ramp_sub = 1'b0;
                        if (ramp_idx == ramp_top) begin
                            next_ramp_state = txc_pkg::RAMP_HOLD;
                            next_hold_cnt = '0;
                        end else begin
                            next_ramp_idx = ramp_idx + 6'h01;
                        end
                    end
                end
                txc_pkg::RAMP_HOLD: begin
                    next_hold_cnt = hold_cnt + 5'h01;
                    if (hold_cnt == ramp_rest) begin
                        next_ramp_state = txc_pkg::RAMP_DOWN;
                    end
                end
                default: begin
                    if (ctrl[txc_pkg::CTRL_RAMP_INTERP] && !ramp_sub) begin
                        next_ramp_sub = 1'b1;
                    end else begin
                        next_ramp_sub = 1'b0;
                        if (ramp_idx == '0) begin
                            next_ramp_state = txc_pkg::RAMP_IDLE;
                        end else begin
                            next_ramp_idx = ramp_idx - 6'h01;
                        end
                    end
                end
            endcase
        end
    end

    // Pipeline carrier: equalizer, fine scaler, ramp multiplier, CIC.
    assign shift_eff = (cic_shift_value < txc_pkg::SHIFT_MIN) ? txc_pkg::SHIFT_MIN :
        (cic_shift_value > txc_pkg::SHIFT_MAX) ? txc_pkg::SHIFT_MAX : cic_shift_value;
    assign cic_run = s3.valid || (cic_left != 8'h00);
    always_comb begin
        next_s1 = '{valid: in_valid, marker: in_marker, d: eq_y};
        next_s2 = '{valid: s1.valid, marker: s1.marker, d: sc_y};
        next_s3 = '{valid: s2.valid, marker: s2.marker, d: rp_y};
        next_cic_left = cic_left;
        if (s3.valid) begin
            next_cic_left = fifth_order_interpolator_interp_factor;
        end else if (cic_left != 8'h00) begin
            next_cic_left = cic_left - 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            ramp_state <= txc_pkg::RAMP_IDLE;
            ramp_idx <= '0;
            ramp_sub <= 1'b0;
            hold_cnt <= '0;
            cic_left <= '0;
            out_valid <= 1'b0;
            out_i <= '0;
            out_q <= '0;
        end else begin
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
            ramp_state <= next_ramp_state;
            ramp_idx <= next_ramp_idx;
            ramp_sub <= next_ramp_sub;
            hold_cnt <= next_hold_cnt;
            cic_left <= next_cic_left;
            out_valid <= cic_run;
            out_i <= cic_out[0];
            out_q <= cic_out[1];
        end
    end

    // Lane 0 carries I, lane 1 carries Q, sharing every control decision.
    for (genvar k = 0; k < 2; k++) begin : g_lane
        logic signed [15:0] x1, x2, y1, y2, next_x1, next_x2, next_y1, next_y2, x, yf;
        logic signed [txc_pkg::ACC_W-1:0] acc;
        logic signed [txc_pkg::ACC_W-1:0] cp [txc_pkg::CIC_ORDER];
        logic signed [txc_pkg::ACC_W-1:0] ai [txc_pkg::CIC_ORDER];
        logic signed [txc_pkg::ACC_W-1:0] next_cp [txc_pkg::CIC_ORDER];
        logic signed [txc_pkg::ACC_W-1:0] next_ai [txc_pkg::CIC_ORDER];
        logic signed [txc_pkg::ACC_W-1:0] cv, tv;
        logic signed [15:0] b1, b2;

        assign x = (k == 0) ? $signed(in_i) : $signed(in_q);
        assign b1 = $signed(equalizer_coef_one);
        assign b2 = $signed(equalizer_coef_two);

        always_comb begin
            acc = 48'(b2 * x) + 48'(b1 * x1) + (48'(x2) <<< txc_pkg::COEF_FRAC)
                - 48'(b1 * y1) - 48'(b2 * y2);
            yf = $signed(sat16(acc >>> txc_pkg::COEF_FRAC));
            next_x1 = in_valid ? x : x1;
            next_x2 = in_valid ? x1 : x2;
            next_y1 = in_valid ? yf : y1;
            next_y2 = in_valid ? y1 : y2;
            eq_y[k] = ctrl[txc_pkg::CTRL_EQ_EN] ? yf : x;
            sc_y[k] = sat16(48'($signed(s1.d[k]) * $signed({1'b0, fine_scale}))
                >>> txc_pkg::SCALE_FRAC);
            rp_y[k] = sat16(48'($signed(s2.d[k]) * $signed({1'b0, gain}))
                >>> txc_pkg::RAMP_FRAC);
            cv = 48'($signed(s3.d[k]));
            for (int j = 0; j < txc_pkg::CIC_ORDER; j++) begin
                next_cp[j] = cp[j];
                if (s3.valid) begin
                    next_cp[j] = cv;
                    cv = cv - cp[j];
                end
            end
            tv = s3.valid ? cv : '0;
            for (int j = 0; j < txc_pkg::CIC_ORDER; j++) begin
                next_ai[j] = ai[j];
                if (cic_run) begin
                    tv = ai[j] + tv;
                    next_ai[j] = tv;
                end
            end
            cic_out[k] = 18'(tv >>> shift_eff);
        end

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                x1 <= '0;
                x2 <= '0;
                y1 <= '0;
                y2 <= '0;
                for (int j = 0; j < txc_pkg::CIC_ORDER; j++) begin
                    cp[j] <= '0;
                    ai[j] <= '0;
                end
            end else begin
                x1 <= next_x1;
                x2 <= next_x2;
                y1 <= next_y1;
                y2 <= next_y2;
                for (int j = 0; j < txc_pkg::CIC_ORDER; j++) begin
                    cp[j] <= next_cp[j];
                    ai[j] <= next_ai[j];
                end
            end
        end
    end
endmodule : txc_chain
`default_nettype wire

// ### bench/txc_chain_monitor.sv
// Checker of the transmit post-filter chain ports.
`timescale 1ns/1ns
`default_nettype none
module txc_chain_monitor (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Observed ports.
    input wire logic in_valid,
    input wire logic [8:0] up_addr,
    input wire logic up_wr,
    input wire logic up_rd,
    input wire logic [15:0] up_wdata,
    input wire logic [15:0] up_rdata,
    input wire logic out_valid,
    input wire logic [11:0] resampling_second_order_stage_interp_m1,
    input wire logic [8:0] resampling_second_order_stage_decim_m1
);
    logic [7:0] lm1, next_lm1, age, next_age;
    logic [5:0] sh, next_sh;
    logic [6:0] ctl, next_ctl;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    always_comb begin
        next_lm1 = (up_wr && up_addr == 9'h009) ? up_wdata[7:0] : lm1;
        next_ctl = (up_wr && up_addr == 9'h00D) ? up_wdata[6:0] : ctl;
        next_sh = (up_wr && up_addr == 9'h006) ? up_wdata[5:0] : sh;
        next_age = in_valid ? 8'h00 : ((age == 8'hFF) ? age : age + 8'h01);
    end
    always_ff @(posedge clk_sys) begin
        lm1 <= rst ? 8'h00 : next_lm1;
        ctl <= rst ? 7'h00 : next_ctl;
        sh <= rst ? 6'h04 : next_sh;
        age <= rst ? 8'hFF : next_age;
    end
    property p_first; in_valid |-> ##4 out_valid; endproperty
    a_first: assert property (p_first) else $error("late first output");
    property p_one; in_valid && lm1 == 8'h00 |-> ##4 out_valid ##1 !out_valid; endproperty
    a_one: assert property (p_one) else $error("burst length wrong");
    property p_win; out_valid |-> age >= 8'h03 && age <= lm1 + 8'h03; endproperty
    a_win: assert property (p_win) else $error("output outside burst");
    property p_lrd; up_rd && !up_wr && up_addr == 9'h009 |=> up_rdata == {8'h00, lm1}; endproperty
    a_lrd: assert property (p_lrd) else $error("factor read wrong");
    property p_srd; up_rd && !up_wr && up_addr == 9'h006 |=> up_rdata == {10'h000, sh}; endproperty
    a_srd: assert property (p_srd) else $error("shift read wrong");
    property p_crd; up_rd && !up_wr && up_addr == 9'h00D |=> up_rdata == {9'h000, ctl}; endproperty
    a_crd: assert property (p_crd) else $error("control read wrong");
    property p_dec; up_wr && up_addr == 9'h007 |-> ##2 {7'h00, resampling_second_order_stage_decim_m1} == $past(up_wdata, 2);
    endproperty
    a_dec: assert property (p_dec) else $error("decimation copy wrong");
    property p_int; up_wr && up_addr == 9'h008 |-> ##2 {4'h0, resampling_second_order_stage_interp_m1} == $past(up_wdata, 2);
    endproperty
    a_int: assert property (p_int) else $error("interpolation copy wrong");
    c_l2: cover property (in_valid && lm1 == 8'h01);
    c_sh5: cover property (out_valid && sh == 6'h05);
    c_eq: cover property (up_wr && up_addr == 9'h00D && up_wdata[5]);
endmodule : txc_chain_monitor
`default_nettype wire

// ### bench/txc_source_model.sv
// Upstream sample source standing in for the coefficient filter.
`timescale 1ns/1ns
`default_nettype none
module txc_source_model (
    // Clock.
    input wire logic clk_sys,
    // Samples toward the chain.
    output logic in_valid = 1'b0,
    output logic in_marker = 1'b0,
    output logic [15:0] in_i = 16'h0000,
    output logic [15:0] in_q = 16'h0000
);
    // Strobes one I/Q pair for one cycle, then leaves the lines inverted.
    task automatic send(input logic [15:0] si, input logic [15:0] sq, input logic mk);
        @(negedge clk_sys);
        in_valid = 1'b1;
        in_marker = mk;
        in_i = si;
        in_q = sq;
        @(negedge clk_sys);
        in_valid = 1'b0;
        in_marker = ~mk;
        in_i = ~si;
        in_q = ~sq;
    endtask : send
endmodule : txc_source_model
`default_nettype wire

// ### bench/tb.sv
// Self-checking testbench of the transmit post-filter chain.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic in_valid, in_marker, up_wr = 1'b0, up_rd = 1'b0, out_valid;
    logic [15:0] in_i, in_q, up_rdata, up_wdata = 16'h0000;
    logic [8:0] up_addr = 9'h000;
    logic [8:0] resampling_second_order_stage_decim_m1;
    logic [11:0] resampling_second_order_stage_interp_m1;
    logic [17:0] out_i, out_q;
    int mismatches = 0;
    int num_checks = 0;
    always #50 clk_sys = ~clk_sys;
    txc_chain txc_chain_inst (.clk_sys(clk_sys), .rst(rst), .in_valid(in_valid),
        .in_marker(in_marker), .in_i(in_i), .in_q(in_q), .up_addr(up_addr), .up_wr(up_wr),
        .up_rd(up_rd), .up_wdata(up_wdata), .up_rdata(up_rdata), .out_valid(out_valid),
        .out_i(out_i), .out_q(out_q), .resampling_second_order_stage_interp_m1(resampling_second_order_stage_interp_m1),
        .resampling_second_order_stage_decim_m1(resampling_second_order_stage_decim_m1));
    txc_source_model txc_source_model_inst (.clk_sys(clk_sys), .in_valid(in_valid),
        .in_marker(in_marker), .in_i(in_i), .in_q(in_q));
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        up_addr = a;
        up_wdata = d;
        up_wr = 1'b1;
        @(negedge clk_sys);
        up_wr = 1'b0;
    endtask : wr
    // Reads one register and compares it with the expected word.
    task automatic rd(input logic [8:0] a, input logic [15:0] exp, input string what);
        @(negedge clk_sys);
        up_addr = a;
        up_rd = 1'b1;
        @(negedge clk_sys);
        up_rd = 1'b0;
        check(what, {2'b00, up_rdata}, {2'b00, exp});
    endtask : rd
    task automatic setup(input logic [15:0] ctl, input logic [15:0] lm1, input logic [15:0] sh);
        rst = 1'b1;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        wr(9'h00D, ctl);
        wr(9'h00E, 16'h2000);
        wr(9'h009, lm1);
        wr(9'h006, sh);
    endtask : setup
    // Sends one sample with Q as the negated I and compares the first output of its burst.
    task automatic samp(input logic [15:0] x, input logic mk, input logic [17:0] e, string what);
        txc_source_model_inst.send(x, -x, mk);
        repeat (3) @(negedge clk_sys);
        if (what.len() > 0) begin
            check("out_valid", {17'h0, out_valid}, 18'h00001);
            check(what, out_i, e);
            check(what, out_q, -e);
        end
        repeat (3) @(negedge clk_sys);
    endtask : samp
    task automatic t_regs();
        setup(16'h0000, 16'h0000, 16'h0004);
        rd(9'h00E, 16'h2000, "fine_scale");
        wr(9'h006, 16'h003F);
        rd(9'h006, 16'h003F, "shift");
        wr(9'h006, 16'h0002);
        rd(9'h006, 16'h0002, "shift");
        wr(9'h009, 16'h001F);
        rd(9'h009, 16'h001F, "fifth_order_interpolator_interp_factor");
        wr(9'h010, 16'h8001);
        rd(9'h010, 16'h8001, "equalizer_coef_one");
        wr(9'h011, 16'h7FFF);
        rd(9'h011, 16'h7FFF, "equalizer_coef_two");
        wr(9'h00D, 16'h0063);
        rd(9'h00D, 16'h0063, "control");
        wr(9'h007, 16'h01FF);
        wr(9'h008, 16'h0FFF);
        repeat (2) @(negedge clk_sys);
        check("decim", {9'h000, resampling_second_order_stage_decim_m1}, 18'h001FF);
        check("interp", {6'h00, resampling_second_order_stage_interp_m1}, 18'h00FFF);
        rd(9'h1FF, 16'h0000, "unmapped");
    endtask : t_regs
    task automatic t_path();
        setup(16'h0000, 16'h0000, 16'h0004);
        samp(16'h4000, 1'b0, 18'h00200, "plain");
        samp(16'hC000, 1'b0, 18'h3FE00, "negative");
        wr(9'h006, 16'h0005);
        samp(16'h4000, 1'b0, 18'h00100, "shift five");
        wr(9'h006, 16'h0002);
        samp(16'h4000, 1'b0, 18'h00200, "shift floor");
        setup(16'h0020, 16'h0000, 16'h0004);
        wr(9'h011, 16'h4000);
        samp(16'h4000, 1'b0, 18'h00200, "eq two");
        samp(16'h0000, 1'b0, 18'h00000, "eq two tail");
        setup(16'h0020, 16'h0000, 16'h0004);
        wr(9'h010, 16'h4000);
        samp(16'h4000, 1'b0, 18'h00000, "eq one");
        samp(16'h0000, 1'b0, 18'h00200, "eq one delay");
    endtask : t_path
    task automatic t_cic_ramp();
        setup(16'h0000, 16'h0001, 16'h0004);
        repeat (4) samp(16'h4000, 1'b0, 18'h00000, "");
        samp(16'h4000, 1'b0, 18'h02000, "interp two");
        setup(16'h0001, 16'h0000, 16'h0004);
        wr(9'h040, 16'h2000);
        wr(9'h017, 16'h0000);
        wr(9'h019, 16'h0000);
        samp(16'h4000, 1'b0, 18'h00000, "ramp idle");
        samp(16'h4000, 1'b1, 18'h00000, "ramp marker");
        samp(16'h4000, 1'b0, 18'h00100, "ramp up");
        rd(9'h01E, 16'h0200, "ramp status");
        setup(16'h0043, 16'h0000, 16'h0004);
        wr(9'h040, 16'h1000);
        wr(9'h041, 16'h3000);
        wr(9'h018, 16'h0001);
        samp(16'h4000, 1'b1, 18'h00000, "interp marker");
        samp(16'h4000, 1'b0, 18'h00080, "interp first");
        samp(16'h4000, 1'b0, 18'h00100, "interp mid");
        samp(16'h4000, 1'b0, 18'h00180, "standard top");
    endtask : t_cic_ramp
    initial begin
        t_regs();
        t_path();
        t_cic_ramp();
        stop_test();
    end
    initial begin
        #2000000;
        mismatches++;
        stop_test();
    end
endmodule : tb
bind txc_chain txc_chain_monitor txc_chain_monitor_inst (.clk_sys(clk_sys), .rst(rst),
    .in_valid(in_valid), .up_addr(up_addr), .up_wr(up_wr), .up_rd(up_rd), .up_wdata(up_wdata),
    .up_rdata(up_rdata), .out_valid(out_valid), .resampling_second_order_stage_interp_m1(resampling_second_order_stage_interp_m1),
    .resampling_second_order_stage_decim_m1(resampling_second_order_stage_decim_m1));
`default_nettype wire
